// ==== shared/smi_regs.svh ====
// register offsets, field positions and reset values of the status mode and interrupt logic
// assumes: included by design and testbench files; bit n counts from the left (msb is bit 0)
`ifndef SMI_REGS_SVH
`define SMI_REGS_SVH

// ----------------------------------------
// apb byte offsets
// ----------------------------------------
`define SMI_OFF_SM1       8'h00
`define SMI_OFF_SM2       8'h04
`define SMI_OFF_SM1_CLR   8'h08
`define SMI_OFF_SM2_CLR   8'h0c
`define SMI_OFF_MICRO_HLD 8'h10
`define SMI_OFF_MACRO_HLD 8'h14
`define SMI_OFF_MICRO_MSK 8'h18
`define SMI_OFF_MACRO_MSK 8'h1c
`define SMI_OFF_ENC       8'h20

// ----------------------------------------
// first status mode register, bit numbers
// ----------------------------------------
`define SM1_BITGEN_SRC    2
`define SM1_BREAKPOINT    4
`define SM1_PROTECT       5
`define SM1_MACRO_IRQ_EN  6
`define SM1_PARITY        8
`define SM1_HALT_EN       9
`define SM1_OVERFLOW      10
`define SM1_FILE_ONE_EN   11
`define SM1_DELAY_IRQ     14
`define SM1_ADAPTER_BUSY  15

// ----------------------------------------
// second status mode register, bit numbers
// ----------------------------------------
`define SM2_AUTO_XFER     0
`define SM2_DEV_READ      1
`define SM2_HOST_WRITE    2
`define SM2_TERMINATE     3
`define SM2_AUTOLOAD      4
`define SM2_MUX_PRIO3     5
`define SM2_PAGE_SEL      7
`define SM2_UNPROT_CHK    9
`define SM2_PANEL_WRITE   10
`define SM2_PANEL_READ    11
`define SM2_FCR_WRITE     12
`define SM2_ENH_XFORM     13
`define SM2_CONSOLE       14
`define SM2_MACRO_RUN     15

// ----------------------------------------
// masks and reset values
// ----------------------------------------
`define SM_FLAG_MASK      16'hf000
`define SM_EXT_MASK       16'h0fff
`define SM1_RESET         16'h0000
`define SM2_RESET         16'h0002
`define MASK_RESET        16'h0000
`define MACRO_LINE_THREE  3
`endif

// ==== shared/smi_pkg.sv ====
// types shared by the status mode and interrupt logic
// assumes: bit vectors are declared [0:15], left bit numbered zero
package smi_pkg;
	// event occurrence pulses from the processor
	typedef struct packed {
		logic breakpoint;
		logic protect_fault;
		logic parity_error;
		logic overflow;
		logic adapter_busy;
	} event_type;

	// set/clear flags microinstruction command
	typedef struct packed {
		logic        set_flags;
		logic        clear_flags;
		logic [0:15] sel;
	} flag_cmd_type;

	// encoder result
	typedef struct packed {
		logic       valid;
		logic [3:0] num;
	} enc_type;

	// mode outputs toward the datapath
	typedef struct packed {
		logic file_one_to_alu;
		logic transform_to_alu;
		logic file_one_rw_ok;
		logic auto_transfer_en;
		logic autoload_en;
		logic transform_cross_page;
		logic s_field_normal;
		logic unprot_check_en;
		logic enhanced_transform_en;
		logic console_to_mir;
		logic micromem_to_mir;
		logic macro_run_en;
	} mode_type;

	// i/o strobe and timing lines
	typedef struct packed {
		logic device_read_strobe;
		logic host_channel_write;
		logic terminate_transfer;
		logic panel_write_drive;
		logic panel_read_drive;
		logic function_ctrl_write;
	} strobe_type;

	// macro interrupt enable gate, one-hot
	typedef enum logic [2:0] {
		GATE_OFF   = 3'b001,
		GATE_ARMED = 3'b010,
		GATE_ON    = 3'b100
	} gate_type;
endpackage

// ==== verilog/irq_priority_encoder.sv ====
// one priority encoder over a holding register and its mask
// assumes: same clock as the holding register, bit 0 is highest priority
`include "smi_regs.svh"
module irq_priority_encoder (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [0:15]      hold,
	input  wire logic [0:15]      mask,
	output smi_pkg::enc_type      enc
);
	logic [0:15]      active;
	smi_pkg::enc_type enc_nxt;
	smi_pkg::enc_type enc_r;

	// a line counts only when held and unmasked
	assign active = hold & mask;

	// scan from lowest priority upward so bit 0 wins
	always_comb begin
		enc_nxt = '0;
		for (int i = 15; i >= 0; i--) begin
			if (active[i]) begin
				enc_nxt.valid = 1'b1;
				enc_nxt.num   = 4'(i);
			end
		end
	end

	// refreshed every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enc_r <= '0;
		end else begin
			enc_r <= enc_nxt;
		end
	end
	assign enc = enc_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_enc_valid;
		enc.valid == (|$past(active));
	endproperty
	a_enc_valid: assert property (p_enc_valid) else $error("encoder valid wrong");

	property p_enc_prio;
		enc.valid |-> ((($past(active) << enc.num) & 16'h8000) != 16'h0000)
			&& (($past(active) >> (16 - enc.num)) == 16'h0000);
	endproperty
	a_enc_prio: assert property (p_enc_prio) else $error("encoder not highest");
endmodule // irq_priority_encoder

// ==== verilog/status_mode_irq.sv ====
// status mode registers, interrupt holding and mask registers, two encoders
// assumes: apb slave on pclk; all other inputs come from logic on pclk
`include "smi_regs.svh"

// Notes on behaviour
// - n register low five bits drive bit generator when source bit set, else microword
// - interrupt test reports nothing unless macro interrupt system bit is set
// - halt code stops processor after its microinstruction only when halt enable set
// - file one enable feeds file one to alu, else transform; gates file access
// - delay bit makes enable take effect on second enable-and-exit microop
// - automatic transfer runs only while its mode bit is one
// - autoload bit puts console interface in autoload mode
// - mux priority three enable bit is the source of macro line three
// - page select bit lets transform cross pages and suppresses s field decoding
// - unprotected-then-protected check runs only while its bit is one
// - enhanced transform follows its mode bit
// - console bit routes console to mir; master clear selects console
// - macroinstructions run only while macro run bit is one
// - event bits latch one on their event and stay set until cleared; they feed no interrupt line
// - driver bits drive the i/o strobe and timing lines
// - eight status bits are flags, twenty-four are external
// - flags change only by set/clear flags commands and survive master clear
// - flags 0-3 and 8-11 map to bits 0-3 of each register
// - external bits set by their signal, cleared by master clear except the console bit, which master clear sets
// - micro holding collects internal, macro holding external requests
// - lower bit number has higher priority in each holding register
// - each mask bit gates the interrupt line of same register and number
// - an encoder per register outputs highest active masked line
module status_mode_irq (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  master_clear,
	input  wire logic [0:15]           sm1_ext_set,
	input  wire logic [0:15]           sm2_ext_set,
	input  wire smi_pkg::event_type    events,
	input  wire smi_pkg::flag_cmd_type flag_cmd,
	input  wire logic [0:15]           micro_irq_req,
	input  wire logic [0:15]           macro_irq_req,
	input  wire logic                  irq_enable_exit,
	input  wire logic                  irq_disable,
	input  wire logic                  halt_code,
	input  wire logic                  micro_done,
	input  wire logic [4:0]            n_low,
	input  wire logic [4:0]            micro_bit_field,
	output logic [4:0]                 bitgen_pos,
	output logic [0:15]                bitgen_word,
	output logic                       processor_halt,
	output logic                       irq_present,
	output smi_pkg::enc_type           micro_enc,
	output smi_pkg::enc_type           macro_enc,
	output smi_pkg::mode_type          modes,
	output smi_pkg::strobe_type        strobes
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [0:15]       sm1_r;
	logic [0:15]       sm1_nxt;
	logic [0:15]       sm2_r;
	logic [0:15]       sm2_nxt;
	logic [0:15]       micro_hold_r;
	logic [0:15]       macro_hold_r;
	logic [0:15]       micro_mask_r;
	logic [0:15]       macro_mask_r;
	logic [0:15]       wdata16;
	logic [0:15]       ev_bits;
	logic [4:0]        bitgen_pos_r;
	logic              halt_r;
	smi_pkg::gate_type gate_r;
	logic              wr_en;
	logic              rd_hit;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// zero wait state: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign wr_en   = psel & penable & pwrite;
	assign wdata16 = pwdata[15:0];

	// address decode, unmapped offsets answer with an error
	always_comb begin
		rd_hit = 1'b1;
		prdata = 32'h0000_0000;
		case (paddr)
			`SMI_OFF_SM1:       prdata[15:0] = sm1_r;
			`SMI_OFF_SM2:       prdata[15:0] = sm2_r;
			`SMI_OFF_SM1_CLR:   prdata = 32'h0000_0000;
			`SMI_OFF_SM2_CLR:   prdata = 32'h0000_0000;
			`SMI_OFF_MICRO_HLD: prdata[15:0] = micro_hold_r;
			`SMI_OFF_MACRO_HLD: prdata[15:0] = macro_hold_r;
			`SMI_OFF_MICRO_MSK: prdata[15:0] = micro_mask_r;
			`SMI_OFF_MACRO_MSK: prdata[15:0] = macro_mask_r;
			`SMI_OFF_ENC:       prdata[9:0]  = {macro_enc, micro_enc};
			default:            rd_hit = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~rd_hit;

	// ----------------------------------------
	// status mode registers
	// ----------------------------------------
	// event occurrence pulses land on their own sm1 bit positions
	always_comb begin
		ev_bits = 16'h0000;
		ev_bits[`SM1_BREAKPOINT]   = events.breakpoint;
		ev_bits[`SM1_PROTECT]      = events.protect_fault;
		ev_bits[`SM1_PARITY]       = events.parity_error;
		ev_bits[`SM1_OVERFLOW]     = events.overflow;
		ev_bits[`SM1_ADAPTER_BUSY] = events.adapter_busy;
	end

	// clears first, then sets, so an event in the clearing cycle is kept
	always_comb begin
		sm1_nxt = sm1_r;
		sm2_nxt = sm2_r;
		// master clear leaves the eight flag bits alone
		if (master_clear) begin
			sm1_nxt = sm1_nxt & `SM_FLAG_MASK;
			sm2_nxt = sm2_nxt & `SM_FLAG_MASK;
			sm2_nxt[`SM2_CONSOLE] = 1'b1;
		end
		if (wr_en && paddr == `SMI_OFF_SM1_CLR) begin
			sm1_nxt = sm1_nxt & ~(wdata16 & `SM_EXT_MASK);
		end
		if (wr_en && paddr == `SMI_OFF_SM2_CLR) begin
			sm2_nxt = sm2_nxt & ~(wdata16 & `SM_EXT_MASK);
		end
		// external sets; flag positions take no external input
		sm1_nxt = sm1_nxt | ((sm1_ext_set | ev_bits) & `SM_EXT_MASK);
		sm2_nxt = sm2_nxt | (sm2_ext_set & `SM_EXT_MASK);
		if (wr_en && paddr == `SMI_OFF_SM1) begin
			sm1_nxt = sm1_nxt | (wdata16 & `SM_EXT_MASK);
		end
		if (wr_en && paddr == `SMI_OFF_SM2) begin
			sm2_nxt = sm2_nxt | (wdata16 & `SM_EXT_MASK);
		end
		// flags 0-3 and 8-11 only; the other eight flags have no storage
		if (flag_cmd.clear_flags) begin
			sm1_nxt[0:3] = sm1_nxt[0:3] & ~flag_cmd.sel[0:3];
			sm2_nxt[0:3] = sm2_nxt[0:3] & ~flag_cmd.sel[8:11];
		end
		if (flag_cmd.set_flags) begin
			sm1_nxt[0:3] = sm1_nxt[0:3] | flag_cmd.sel[0:3];
			sm2_nxt[0:3] = sm2_nxt[0:3] | flag_cmd.sel[8:11];
		end
	end

	// status mode storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sm1_r <= `SM1_RESET;
			sm2_r <= `SM2_RESET;
		end else begin
			sm1_r <= sm1_nxt;
			sm2_r <= sm2_nxt;
		end
	end

	// ----------------------------------------
	// holding and mask registers
	// ----------------------------------------
	// requests are levels from the peripherals, captured every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			micro_hold_r <= 16'h0000;
			macro_hold_r <= 16'h0000;
		end else begin
			micro_hold_r <= micro_irq_req;
			macro_hold_r <= macro_irq_req;
			macro_hold_r[`MACRO_LINE_THREE] <= sm2_r[`SM2_MUX_PRIO3];
		end
	end

	// masks written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			micro_mask_r <= `MASK_RESET;
			macro_mask_r <= `MASK_RESET;
		end else begin
			if (wr_en && paddr == `SMI_OFF_MICRO_MSK) begin
				micro_mask_r <= wdata16;
			end
			if (wr_en && paddr == `SMI_OFF_MACRO_MSK) begin
				macro_mask_r <= wdata16;
			end
		end
	end

	// ----------------------------------------
	// priority encoders
	// ----------------------------------------
	irq_priority_encoder u_micro_enc (
		.pclk    (pclk),
		.presetn (presetn),
		.hold    (micro_hold_r),
		.mask    (micro_mask_r),
		.enc     (micro_enc)
	);

	irq_priority_encoder u_macro_enc (
		.pclk    (pclk),
		.presetn (presetn),
		.hold    (macro_hold_r),
		.mask    (macro_mask_r),
		.enc     (macro_enc)
	);

	// ----------------------------------------
	// macro interrupt enable gate
	// ----------------------------------------
	// the delay bit holds off the enable for one extra enable-and-exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_r <= smi_pkg::GATE_OFF;
		end else if (master_clear || irq_disable) begin
			gate_r <= smi_pkg::GATE_OFF;
		end else if (irq_enable_exit) begin
			case (gate_r)
				smi_pkg::GATE_OFF: begin
					gate_r <= sm1_r[`SM1_DELAY_IRQ] ? smi_pkg::GATE_ARMED : smi_pkg::GATE_ON;
				end
				smi_pkg::GATE_ARMED: gate_r <= smi_pkg::GATE_ON;
				smi_pkg::GATE_ON:    gate_r <= smi_pkg::GATE_ON;
				default:             gate_r <= smi_pkg::GATE_OFF;
			endcase
		end
	end

	// interrupt test sees nothing while the system bit is clear
	assign irq_present = sm1_r[`SM1_MACRO_IRQ_EN] & (gate_r == smi_pkg::GATE_ON) & macro_enc.valid;

	// ----------------------------------------
	// bit generator and halt
	// ----------------------------------------
	// position register; word is all zero for positions beyond 15
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitgen_pos_r <= 5'h00;
		end else begin
			bitgen_pos_r <= sm1_r[`SM1_BITGEN_SRC] ? n_low : micro_bit_field;
		end
	end
	assign bitgen_pos  = bitgen_pos_r;
	assign bitgen_word = 16'h8000 >> bitgen_pos_r;

	// halt waits for the halting microinstruction to complete
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_r <= 1'b0;
		end else if (micro_done && halt_code && sm1_r[`SM1_HALT_EN]) begin
			halt_r <= 1'b1;
		end else if (master_clear) begin
			halt_r <= 1'b0;
		end
	end
	assign processor_halt = halt_r;

	// ----------------------------------------
	// mode and strobe outputs
	// ----------------------------------------
	assign modes.file_one_to_alu       = sm1_r[`SM1_FILE_ONE_EN];
	assign modes.transform_to_alu      = ~sm1_r[`SM1_FILE_ONE_EN];
	assign modes.file_one_rw_ok        = sm1_r[`SM1_FILE_ONE_EN];
	assign modes.auto_transfer_en      = sm2_r[`SM2_AUTO_XFER];
	assign modes.autoload_en           = sm2_r[`SM2_AUTOLOAD];
	assign modes.transform_cross_page  = sm2_r[`SM2_PAGE_SEL];
	assign modes.s_field_normal        = ~sm2_r[`SM2_PAGE_SEL];
	assign modes.unprot_check_en       = sm2_r[`SM2_UNPROT_CHK];
	assign modes.enhanced_transform_en = sm2_r[`SM2_ENH_XFORM];
	assign modes.console_to_mir        = sm2_r[`SM2_CONSOLE];
	assign modes.micromem_to_mir       = ~sm2_r[`SM2_CONSOLE];
	assign modes.macro_run_en          = sm2_r[`SM2_MACRO_RUN];

	// driver bits are firmware-timed strobes; they stay up until cleared
	assign strobes.device_read_strobe  = sm2_r[`SM2_DEV_READ];
	assign strobes.host_channel_write  = sm2_r[`SM2_HOST_WRITE];
	assign strobes.terminate_transfer  = sm2_r[`SM2_TERMINATE];
	assign strobes.panel_write_drive   = sm2_r[`SM2_PANEL_WRITE];
	assign strobes.panel_read_drive    = sm2_r[`SM2_PANEL_READ];
	assign strobes.function_ctrl_write = sm2_r[`SM2_FCR_WRITE];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_bitgen_src;
		##1 bitgen_pos == ($past(sm1_r[`SM1_BITGEN_SRC]) ? $past(n_low) : $past(micro_bit_field));
	endproperty
	a_bitgen_src: assert property (p_bitgen_src) else $error("bit generator source wrong");

	property p_interrupt_test_logic_off;
		!sm1_r[`SM1_MACRO_IRQ_EN] |-> !irq_present;
	endproperty
	a_interrupt_test_logic_off: assert property (p_interrupt_test_logic_off) else $error("interrupt seen while disabled");

	property p_halt;
		!processor_halt && !(micro_done && halt_code && sm1_r[`SM1_HALT_EN]) |=> !processor_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("halt without enabled halt code");

	property p_delay;
		gate_r == smi_pkg::GATE_OFF && irq_enable_exit && sm1_r[`SM1_DELAY_IRQ]
			&& !master_clear && !irq_disable |=> gate_r == smi_pkg::GATE_ARMED;
	endproperty
	a_delay: assert property (p_delay) else $error("delayed enable not deferred");

	property p_line3;
		##1 macro_hold_r[`MACRO_LINE_THREE] == $past(sm2_r[`SM2_MUX_PRIO3]);
	endproperty
	a_line3: assert property (p_line3) else $error("line three not from its bit");

	property p_event;
		events.overflow |=> sm1_r[`SM1_OVERFLOW] [*1];
	endproperty
	a_event: assert property (p_event) else $error("event not latched");

	property p_flags_kept;
		master_clear && !flag_cmd.set_flags && !flag_cmd.clear_flags
			|=> sm1_r[0:3] == $past(sm1_r[0:3]) && sm2_r[0:3] == $past(sm2_r[0:3]);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flags lost on master clear");

	property p_ext_clear;
		master_clear && sm1_ext_set == 16'h0000 && ev_bits == 16'h0000 && !wr_en
			|=> (sm1_r & `SM_EXT_MASK) == 16'h0000;
	endproperty
	a_ext_clear: assert property (p_ext_clear) else $error("external bits kept");

	property p_console_mc;
		master_clear |=> modes.console_to_mir;
	endproperty
	a_console_mc: assert property (p_console_mc) else $error("master clear left mir on micromemory");

	c_irq: cover property (irq_present);
	c_delay: cover property (gate_r == smi_pkg::GATE_ARMED ##[1:20] gate_r == smi_pkg::GATE_ON);
	c_halt: cover property ($rose(processor_halt));
endmodule // status_mode_irq

// ==== verification/seq_model.sv ====
// far-side model: microsequencer and i/o controllers around the status and interrupt block
// assumes: pulse is called right after a rising pclk edge; levels are driven by the bench
module seq_model (
	input  wire logic              pclk,
	output logic                   master_clear,
	output logic [0:15]            sm1_ext_set,
	output logic [0:15]            sm2_ext_set,
	output smi_pkg::event_type     events,
	output smi_pkg::flag_cmd_type  flag_cmd,
	output logic [0:15]            micro_irq_req,
	output logic [0:15]            macro_irq_req,
	output logic                   irq_enable_exit,
	output logic                   irq_disable,
	output logic                   halt_code,
	output logic                   micro_done,
	output logic [4:0]             n_low,
	output logic [4:0]             micro_bit_field
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----
	// idle levels
	// ----
	initial begin
		{master_clear, sm1_ext_set, sm2_ext_set, events, flag_cmd, micro_irq_req, macro_irq_req} = '0;
		{irq_enable_exit, irq_disable, halt_code, micro_done, n_low, micro_bit_field} = '0;
	end

	// one-cycle strobes; op: clear, set flags, clear flags, exit, disable, done, ext1, ext2
	// a second edge passes so two pulses never merge into one level
	task automatic pulse(input logic [7:0] op, input logic [4:0] ev, input logic [15:0] v);
		{master_clear, flag_cmd.set_flags, flag_cmd.clear_flags} <= op[7:5];
		{irq_enable_exit, irq_disable, micro_done} <= op[4:2];
		flag_cmd.sel <= v;
		sm1_ext_set <= op[1] ? v : 16'h0000;
		sm2_ext_set <= op[0] ? v : 16'h0000;
		events <= ev;
		@(posedge pclk);
		{master_clear, flag_cmd, irq_enable_exit, irq_disable, micro_done, sm1_ext_set, sm2_ext_set, events} <= '0;
		@(posedge pclk);
	endtask
endmodule // seq_model

// ==== verification/testbench.sv ====
// self-checking bench: apb master, integer model of both status registers and both encoders
// assumes: seq_model drives the processor side; bit k of a 16-bit value sits at numeric bit 15-k
`include "smi_regs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic			pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]		paddr = 8'h00;
	logic [31:0]		pwdata = 32'h0, prdata, r, r2, seed = 32'hd24a;
	logic			pready, pslverr, master_clear, irq_enable_exit, irq_disable, halt_code, micro_done;
	logic			processor_halt, irq_present, er;
	logic [0:15]		sm1_ext_set, sm2_ext_set, micro_irq_req, macro_irq_req, bitgen_word;
	logic [4:0]		n_low, micro_bit_field, bitgen_pos;
	logic [15:0]		rd;
	smi_pkg::event_type	events;
	smi_pkg::flag_cmd_type	flag_cmd;
	smi_pkg::enc_type	micro_enc, macro_enc;
	smi_pkg::mode_type	modes;
	smi_pkg::strobe_type	strobes;
	int			n_mismatch = 0, tests_run = 0, sm1_m = 0, sm2_m = `SM2_RESET;
	int			eb[5] = '{`SM1_BREAKPOINT, `SM1_PROTECT, `SM1_PARITY, `SM1_OVERFLOW, `SM1_ADAPTER_BUSY};

	always #10 pclk = ~pclk;

	status_mode_irq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.master_clear, .sm1_ext_set, .sm2_ext_set, .events, .flag_cmd, .micro_irq_req, .macro_irq_req,
		.irq_enable_exit, .irq_disable, .halt_code, .micro_done, .n_low, .micro_bit_field, .bitgen_pos,
		.bitgen_word, .processor_halt, .irq_present, .micro_enc, .macro_enc, .modes, .strobes);
	seq_model seq (.pclk, .master_clear, .sm1_ext_set, .sm2_ext_set, .events, .flag_cmd, .micro_irq_req,
		.macro_irq_req, .irq_enable_exit, .irq_disable, .halt_code, .micro_done, .n_low, .micro_bit_field);

	// ----
	// model helpers
	// ----
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int bv(int k); return 1 << (15 - k); endfunction
	function automatic logic b(int v, int k); return v[15 - k]; endfunction
	// highest set line, lowest bit number first
	function automatic logic [4:0] pe(int h);
		for (int k = 0; k < 16; k++)
			if (h & bv(k)) return {1'b1, 4'(k)};
		return 5'h00;
	endfunction
	function automatic logic [11:0] mexp();
		return {b(sm1_m, 11), !b(sm1_m, 11), b(sm1_m, 11), b(sm2_m, 0), b(sm2_m, 4), b(sm2_m, 7),
			!b(sm2_m, 7), b(sm2_m, 9), b(sm2_m, 13), b(sm2_m, 14), !b(sm2_m, 14), b(sm2_m, 15)};
	endfunction

	// ----
	// bus and comparison tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// setup then access, held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int t;
		t = 0;
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && t < 20) begin
			@(posedge pclk);
			t++;
		end
		if (t == 20) n_mismatch++;
		rd = prdata[15:0];
		er = pslverr;
		{psel, penable} <= 2'b00;
		// one idle edge: the write is visible and psel is never assigned twice in a step
		@(posedge pclk);
	endtask
	// apb only reaches external bits: set at the plain offset, cleared at the clear offset
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
		if (a == `SMI_OFF_SM1) sm1_m |= d & `SM_EXT_MASK;
		if (a == `SMI_OFF_SM2) sm2_m |= d & `SM_EXT_MASK;
		if (a == `SMI_OFF_SM1_CLR) sm1_m &= ~(d & `SM_EXT_MASK);
		if (a == `SMI_OFF_SM2_CLR) sm2_m &= ~(d & `SM_EXT_MASK);
	endtask
	task automatic mclr();
		seq.pulse(8'h80, 5'h00, 16'h0000);
		sm1_m &= `SM_FLAG_MASK;
		sm2_m = sm2_m & `SM_FLAG_MASK | `SM2_RESET;
	endtask
	task automatic cmp_sm();
		apb(1'b0, `SMI_OFF_SM1, 16'h0000);
		check(rd, sm1_m[15:0]);
		apb(1'b0, `SMI_OFF_SM2, 16'h0000);
		check(rd, sm2_m[15:0]);
		check(modes, mexp());
		check(strobes, {b(sm2_m, 1), b(sm2_m, 2), b(sm2_m, 3), b(sm2_m, 10), b(sm2_m, 11), b(sm2_m, 12)});
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard, well beyond the roughly five hundred cycles the sequence needs
	initial begin
		#400000;
		n_mismatch++;
		final_report();
	end

	// ----
	// main sequence
	// ----
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		cmp_sm();
		wr(`SMI_OFF_MICRO_HLD, 16'hffff);
		apb(1'b0, `SMI_OFF_MICRO_HLD, 16'h0000);
		check(rd, 16'h0000);
		apb(1'b0, `SMI_OFF_MICRO_MSK, 16'h0000);
		check(rd, `MASK_RESET);
		apb(1'b0, 8'h24, 16'h0000);
		check(er, 1'b1);
		// flags: commands only, unaddressed flags land nowhere, master clear leaves them
		seq.pulse(8'h40, 5'h00, 16'hffff);
		sm1_m |= 16'hf000;
		sm2_m |= 16'hf000;
		wr(`SMI_OFF_SM1, 16'hffff);
		wr(`SMI_OFF_SM2, 16'hffff);
		cmp_sm();
		seq.pulse(8'h20, 5'h00, 16'h0f0f);
		cmp_sm();
		seq.pulse(8'h20, 5'h00, 16'h5050);
		sm1_m &= ~16'h5000;
		sm2_m &= ~16'h5000;
		wr(`SMI_OFF_SM1_CLR, 16'h0a0a);
		cmp_sm();
		mclr();
		cmp_sm();
		seq.pulse(8'h03, 5'h00, 16'hffff);
		sm1_m |= `SM_EXT_MASK;
		sm2_m |= `SM_EXT_MASK;
		cmp_sm();
		// each event latches its own bit
		mclr();
		for (int i = 0; i < 5; i++) begin
			seq.pulse(8'h00, 5'h10 >> i, 16'h0000);
			sm1_m |= bv(eb[i]);
			apb(1'b0, `SMI_OFF_SM1, 16'h0000);
			check(rd, sm1_m[15:0]);
		end
		// random mode and driver settings
		for (int i = 0; i < 8; i++) begin
			r = xs();
			wr(`SMI_OFF_SM1_CLR, ~r[15:0]);
			wr(`SMI_OFF_SM1, r[15:0]);
			wr(`SMI_OFF_SM2_CLR, ~r[31:16]);
			wr(`SMI_OFF_SM2, r[31:16]);
			cmp_sm();
		end
		// random requests and masks; macro line three follows its status bit
		for (int i = 0; i < 12; i++) begin
			r = xs();
			r2 = xs();
			wr(`SMI_OFF_MICRO_MSK, r[15:0]);
			wr(`SMI_OFF_MACRO_MSK, r[31:16]);
			seq.micro_irq_req <= r2[15:0];
			seq.macro_irq_req <= r2[31:16];
			wr(r2[0] ? `SMI_OFF_SM2 : `SMI_OFF_SM2_CLR, 16'h0400);
			repeat (3) @(posedge pclk);
			check(micro_enc, pe(r2[15:0] & r[15:0]));
			r2[31:16] = (r2[31:16] & ~16'h1000 | (b(sm2_m, 5) ? 16'h1000 : 16'h0000)) & r[31:16];
			check(macro_enc, pe(r2[31:16]));
			apb(1'b0, `SMI_OFF_ENC, 16'h0000);
			check(rd[9:0], {pe(r2[31:16]), pe(r2[15:0] & r[15:0])});
		end
		// interrupt test gate, plain and delayed
		wr(`SMI_OFF_SM1_CLR, 16'hffff);
		wr(`SMI_OFF_MACRO_MSK, 16'hffff);
		seq.macro_irq_req <= 16'h8000;
		wr(`SMI_OFF_SM1, bv(`SM1_MACRO_IRQ_EN));
		seq.pulse(8'h10, 5'h00, 16'h0000);
		check(irq_present, 1'b1);
		seq.pulse(8'h08, 5'h00, 16'h0000);
		check(irq_present, 1'b0);
		wr(`SMI_OFF_SM1, bv(`SM1_DELAY_IRQ));
		seq.pulse(8'h10, 5'h00, 16'h0000);
		check(irq_present, 1'b0);
		seq.pulse(8'h10, 5'h00, 16'h0000);
		check(irq_present, 1'b1);
		wr(`SMI_OFF_SM1_CLR, bv(`SM1_MACRO_IRQ_EN));
		check(irq_present, 1'b0);
		// halt code only counts with the halt enable bit
		seq.halt_code <= 1'b1;
		seq.pulse(8'h04, 5'h00, 16'h0000);
		check(processor_halt, 1'b0);
		wr(`SMI_OFF_SM1, bv(`SM1_HALT_EN));
		seq.pulse(8'h04, 5'h00, 16'h0000);
		check(processor_halt, 1'b1);
		mclr();
		check(processor_halt, 1'b0);
		// bit generator source is flag 2, reached by flag commands only; a position past 15 gives an empty word
		seq.n_low <= 5'd7;
		seq.micro_bit_field <= 5'd20;
		seq.pulse(8'h20, 5'h00, 16'h2000);
		sm1_m &= ~bv(`SM1_BITGEN_SRC);
		repeat (2) @(posedge pclk);
		check(bitgen_pos, 5'd20);
		check(bitgen_word, 16'h0000);
		seq.pulse(8'h40, 5'h00, 16'h2000);
		sm1_m |= bv(`SM1_BITGEN_SRC);
		repeat (2) @(posedge pclk);
		check(bitgen_pos, 5'd7);
		check(bitgen_word, bv(7));
		final_report();
	end
endmodule // testbench
